// ---- common/gsc_pkg.sv ----
/*
 * Shared constants of the gateway status and control byte logic.
 * Assumes one 125 MHz clock domain and the process image handled by the
 * fieldbus side as whole bytes.
 */
// Summary of operation
// - Toggle block-ready on each buffered block load.
// - Set sticky data-loss flag when data lost.
// - Truncate oversized messages, keep head, flag loss.
// - Overflow flag follows full buffer, clears itself.
// - Hold RTS deasserted while overflow flag set.
// - One 1 kByte store shared by both directions.
// - Transparent mode toggles new-data per data set.
// - Status byte 1 holds user byte count.
// - Control byte 0 field layout.
// - Control byte 1 field layout.
// - Broadcast and address used only with coupler.
// - Status flags read zero after reset.
// - Toggle write-acknowledge on finished copy or send from buffer.
// - Read-acknowledge change loads next block.
// - Data-pending flag high while receive buffer holds data.
// - Command mode keeps master data off serial.
package gsc_pkg;

	// ********************************************************
	// Sizes
	// ********************************************************
	localparam int FRAME_BYTES_DEF = 8;
	localparam int BUF_BYTES_DEF   = 1024;

	// ********************************************************
	// Status byte 0 bit positions
	// ********************************************************
	localparam int ST0_WACK = 0;
	localparam int ST0_DEX  = 3;
	localparam int ST0_BLR  = 4;
	localparam int ST0_DL   = 5;
	localparam int ST0_BO   = 6;
	localparam int ST0_ND   = 7;

	// ********************************************************
	// Control byte bit positions
	// ********************************************************
	localparam int CT0_CMD   = 0;
	localparam int CT0_BCAST = 1;
	localparam int CT0_ADDR  = 2;
	localparam int CT0_ND    = 7;
	localparam int CT1_RACK  = 0;
	localparam int CT1_SFB   = 2;
	localparam int CT1_CTB   = 3;

	// ********************************************************
	// Reset values and pending event slots
	// ********************************************************
	localparam logic [7:0] STATUS0_RST = 8'h00;
	localparam logic [7:0] STATUS1_RST = 8'h00;
	localparam logic [7:0] CTRL_RST    = 8'h00;
	localparam int EV_RACK = 0;
	localparam int EV_SFB  = 1;
	localparam int EV_CTB  = 2;
	localparam int EV_ND   = 3;

	typedef enum logic [3:0] {
		GSC_IDLE = 4'b0001,
		GSC_LOAD = 4'b0010,
		GSC_COPY = 4'b0100,
		GSC_SEND = 4'b1000
	} gsc_state_e;

endpackage

// ---- common/gsc_ctrl_if.sv ----
/*
 * Decoded master control image passed from the decoder to the core.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface gsc_ctrl_if #(parameter int FB = 8);
	logic          cmd_mode;
	logic          bcast;
	logic [4:0]    addr;
	logic [FB*8-1:0] data;
	logic [7:0]    len;
	logic [3:0]    ev;

	modport dec  (output cmd_mode, bcast, addr, data, len, ev);
	modport core (input  cmd_mode, bcast, addr, data, len, ev);
endinterface
`default_nettype wire

// ---- hdl/gsc_fifo.sv ----
/*
 * Byte FIFO with its own storage array and a live occupancy count.
 * Assumes the user never pushes when full nor pops when empty.
 */
`timescale 1ns/1ps
`default_nettype none
module gsc_fifo #(
	parameter int DEPTH = 1024,
	parameter int CW    = $clog2(DEPTH + 1)
) (
	input  wire logic          clk,   // System clock.
	input  wire logic          rst_n, // Asynchronous reset, active low.
	input  wire logic          push,  // Write one byte.
	input  wire logic [7:0]    din,   // Byte to write.
	input  wire logic          pop,   // Drop the head byte.
	output logic      [7:0]    dout,  // Head byte.
	output logic      [CW-1:0] count, // Bytes held.
	output logic               empty  // No byte held.
);
	localparam int AW = $clog2(DEPTH);

	logic [7:0]    mem [DEPTH];
	logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [CW-1:0] cnt_q, cnt_d;

	always_comb begin
		wp_d  = push ? AW'(wp_q + 1'b1) : wp_q;
		rp_d  = pop ? AW'(rp_q + 1'b1) : rp_q;
		cnt_d = CW'(cnt_q + CW'(push) - CW'(pop));
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_q  <= '0;
			rp_q  <= '0;
			cnt_q <= '0;
		end else begin
			wp_q  <= wp_d;
			rp_q  <= rp_d;
			cnt_q <= cnt_d;
		end
	end

	// Storage has no reset so that it maps onto plain RAM.
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wp_q] <= din;
		end
	end

	assign dout  = mem[rp_q];
	assign count = cnt_q;
	assign empty = (cnt_q == '0);
endmodule // gsc_fifo
`default_nettype wire

// ---- hdl/gsc_ctrl_decode.sv ----
/*
 * Holds the master control image and turns bit changes into events.
 * Assumes img_wr pulses once per process image update from the master.
 */
`timescale 1ns/1ps
`default_nettype none
module gsc_ctrl_decode #(
	parameter int FB = 8
) (
	input  wire logic            clk,    // System clock.
	input  wire logic            rst_n,  // Asynchronous reset, active low.
	input  wire logic            img_wr, // Master image update strobe.
	input  wire logic [7:0]      ctrl0,  // Control byte 0 from master.
	input  wire logic [7:0]      ctrl1,  // Control byte 1 from master.
	input  wire logic [FB*8-1:0] m_data, // Master data bytes.
	input  wire logic [7:0]      m_len,  // Master data byte count.
	gsc_ctrl_if.dec              ctl     // Decoded control toward core.
);
	import gsc_pkg::*;

	logic [7:0]      c0_q, c0_d, c1_q, c1_d, len_q, len_d;
	logic [FB*8-1:0] dat_q, dat_d;
	logic [3:0]      ev_q, ev_d;

	always_comb begin
		c0_d  = img_wr ? ctrl0 : c0_q;
		c1_d  = img_wr ? ctrl1 : c1_q;
		dat_d = img_wr ? m_data : dat_q;
		len_d = img_wr ? m_len : len_q;
		ev_d  = '0;
		if (img_wr) begin
			ev_d[EV_RACK] = ctrl1[CT1_RACK] ^ c1_q[CT1_RACK];
			ev_d[EV_SFB]  = ctrl1[CT1_SFB] ^ c1_q[CT1_SFB];
			ev_d[EV_CTB]  = ctrl1[CT1_CTB] ^ c1_q[CT1_CTB];
			ev_d[EV_ND]   = ctrl0[CT0_ND] ^ c0_q[CT0_ND];
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			c0_q  <= CTRL_RST;
			c1_q  <= CTRL_RST;
			len_q <= '0;
			dat_q <= '0;
			ev_q  <= '0;
		end else begin
			c0_q  <= c0_d;
			c1_q  <= c1_d;
			len_q <= len_d;
			dat_q <= dat_d;
			ev_q  <= ev_d;
		end
	end

	assign ctl.cmd_mode = c0_q[CT0_CMD];
	assign ctl.bcast    = c0_q[CT0_BCAST];
	assign ctl.addr     = c0_q[CT0_ADDR +: 5];
	assign ctl.data     = dat_q;
	assign ctl.len      = len_q;
	assign ctl.ev       = ev_q;
endmodule // gsc_ctrl_decode
`default_nettype wire

// ---- hdl/gsc_gateway.sv ----
/*
 * Status and control byte handshake core of the serial fieldbus gateway.
 * Assumes the master image and the serial byte streams are synchronous
 * to clk, and that serial framing is added and removed outside.
 */
`timescale 1ns/1ps
`default_nettype none
module gsc_gateway #(
	parameter int FB  = gsc_pkg::FRAME_BYTES_DEF,
	parameter int BUF = gsc_pkg::BUF_BYTES_DEF
) (
	input  wire logic            clk,           // System clock.
	input  wire logic            rst_n,         // Async reset, active low.
	input  wire logic            transparent,   // 1 transparent, 0 blocks.
	input  wire logic            coupler,       // Multi-drop coupler fitted.
	input  wire logic            img_wr,        // Master image update.
	input  wire logic [7:0]      ctrl0,         // Control byte 0.
	input  wire logic [7:0]      ctrl1,         // Control byte 1.
	input  wire logic [FB*8-1:0] m_data,        // Master data bytes.
	input  wire logic [7:0]      m_len,         // Master data count.
	output logic      [7:0]      status0,       // Status byte 0.
	output logic      [7:0]      status1,       // Status byte 1.
	output logic      [FB*8-1:0] in_data,       // Data bytes to master.
	input  wire logic            ser_rx_valid,  // Serial byte received.
	input  wire logic [7:0]      ser_rx_data,   // Received byte.
	input  wire logic            ser_rx_last,   // Last byte of message.
	output logic                 rts,           // Serial RTS, 1 asserted.
	output logic                 ser_tx_valid,  // Byte for serial side.
	output logic      [7:0]      ser_tx_data,   // Byte to send.
	output logic                 ser_tx_last,   // Last byte of message.
	input  wire logic            ser_tx_ready,  // Serial side takes byte.
	output logic                 tx_bcast,      // Send as broadcast.
	output logic      [4:0]      tx_addr,       // Slave address prefix.
	output logic                 cmd_valid,     // Command data pulse.
	output logic      [FB*8-1:0] cmd_data,      // Command bytes.
	output logic      [7:0]      cmd_len        // Command byte count.
);
	import gsc_pkg::*;

	localparam int CW = $clog2(BUF + 1);

	// ********************************************************
	// Control decode and buffer storage
	// ********************************************************
	gsc_ctrl_if #(.FB(FB)) ctl ();

	gsc_ctrl_decode #(.FB(FB)) u_dec (
		.clk    (clk),
		.rst_n  (rst_n),
		.img_wr (img_wr),
		.ctrl0  (ctrl0),
		.ctrl1  (ctrl1),
		.m_data (m_data),
		.m_len  (m_len),
		.ctl    (ctl.dec)
	);

	logic          rx_push, rx_pop, rx_empty, tx_push, tx_pop, tx_empty;
	logic [7:0]    rx_dout, tx_dout, tx_din;
	logic [CW-1:0] rx_count, tx_count;
	logic [CW:0]   total;
	logic          room, room_tx;

	// Both directions draw from one pool; each FIFO is sized to the pool
	// because either side may use all of it.
	gsc_fifo #(.DEPTH(BUF)) u_rxbuf (
		.clk   (clk),
		.rst_n (rst_n),
		.push  (rx_push),
		.din   (ser_rx_data),
		.pop   (rx_pop),
		.dout  (rx_dout),
		.count (rx_count),
		.empty (rx_empty)
	);

	gsc_fifo #(.DEPTH(BUF)) u_txbuf (
		.clk   (clk),
		.rst_n (rst_n),
		.push  (tx_push),
		.din   (tx_din),
		.pop   (tx_pop),
		.dout  (tx_dout),
		.count (tx_count),
		.empty (tx_empty)
	);

	assign total   = (CW + 1)'(rx_count) + (CW + 1)'(tx_count);
	assign room    = total < (CW + 1)'(BUF);
	assign room_tx = (total + (CW + 1)'(rx_push)) < (CW + 1)'(BUF);

	// ********************************************************
	// State
	// ********************************************************
	gsc_state_e      st_q, st_d;
	logic [FB*8-1:0] sh_q, sh_d, in_q, in_d, cd_q, cd_d;
	logic [7:0]      cnt_q, cnt_d, idx_q, idx_d, s0_q, s0_d, s1_q, s1_d;
	logic [7:0]      cl_q, cl_d, tx_q, tx_d;
	logic            trunc_q, trunc_d, rts_q, rts_d, tv_q, tv_d;
	logic            tl_q, tl_d, tb_q, tb_d, cv_q, cv_d, fsrc_q, fsrc_d;
	logic [4:0]      ta_q, ta_d;
	logic [3:0]      pend_q, pend_d;
	logic [7:0]      nlim;
	logic            more, adv;

	// Bytes of the master image that fit into one frame.
	assign nlim = (ctl.len > 8'(FB)) ? 8'(FB) : ctl.len;
	assign more = fsrc_q ? !tx_empty : (idx_q < nlim);
	assign adv  = !tv_q || ser_tx_ready;

	always_comb begin
		st_d    = st_q;
		sh_d    = sh_q;
		in_d    = in_q;
		cnt_d   = cnt_q;
		idx_d   = idx_q;
		trunc_d = trunc_q;
		s0_d    = s0_q;
		s1_d    = s1_q;
		tv_d    = tv_q;
		tx_d    = tx_q;
		tl_d    = tl_q;
		tb_d    = tb_q;
		ta_d    = ta_q;
		fsrc_d  = fsrc_q;
		cv_d    = 1'b0;
		cd_d    = cd_q;
		cl_d    = cl_q;
		rx_push = 1'b0;
		rx_pop  = 1'b0;
		tx_push = 1'b0;
		tx_pop  = 1'b0;
		tx_din  = ctl.data[idx_q*8 +: 8];
		// New events are merged after any clear, so none is dropped.
		pend_d  = pend_q;

		// Serial receive path.
		if (ser_rx_valid && !transparent) begin
			if (room) begin
				rx_push = 1'b1;
			end else begin
				s0_d[ST0_DL] = 1'b1;
			end
		end else if (ser_rx_valid) begin
			if (cnt_q < 8'(FB)) begin
				sh_d[cnt_q*8 +: 8] = ser_rx_data;
				cnt_d = 8'(cnt_q + 1'b1);
			end else begin
				trunc_d = 1'b1;
			end
			if (ser_rx_last) begin
				in_d           = sh_d;
				s1_d           = cnt_d;
				s0_d[ST0_ND]   = !s0_q[ST0_ND];
				s0_d[ST0_DL]   = s0_q[ST0_DL] | trunc_d;
				sh_d           = '0;
				cnt_d          = '0;
				trunc_d        = 1'b0;
			end
		end

		case (st_q)
			GSC_IDLE: begin
				idx_d = '0;
				if (pend_q[EV_RACK]) begin
					pend_d[EV_RACK] = 1'b0;
					if (!transparent) begin
						st_d  = GSC_LOAD;
						sh_d  = '0;
						cnt_d = '0;
					end
				end else if (pend_q[EV_CTB]) begin
					pend_d[EV_CTB] = 1'b0;
					if (!ctl.cmd_mode) begin
						st_d = GSC_COPY;
					end
				end else if (pend_q[EV_SFB] || pend_q[EV_ND]) begin
					fsrc_d = pend_q[EV_SFB];
					if (pend_q[EV_SFB]) begin
						pend_d[EV_SFB] = 1'b0;
					end else begin
						pend_d[EV_ND] = 1'b0;
					end
					if (ctl.cmd_mode) begin
						// Command data goes to the command decoder only.
						cv_d = !pend_q[EV_SFB];
						cd_d = ctl.data;
						cl_d = nlim;
					end else if (pend_q[EV_SFB] || transparent) begin
						st_d = GSC_SEND;
						tb_d = coupler & ctl.bcast;
						ta_d = coupler ? ctl.addr : 5'h0_0;
					end
				end
			end
			GSC_LOAD: begin
				if (!rx_empty && cnt_q < 8'(FB)) begin
					rx_pop = 1'b1;
					sh_d[cnt_q*8 +: 8] = rx_dout;
					cnt_d = 8'(cnt_q + 1'b1);
				end else begin
					// An empty buffer yields a zeroed block of length 0.
					in_d          = sh_q;
					s1_d          = cnt_q;
					s0_d[ST0_BLR] = !s0_q[ST0_BLR];
					sh_d          = '0;
					cnt_d         = '0;
					st_d          = GSC_IDLE;
				end
			end
			GSC_COPY: begin
				if (idx_q < nlim) begin
					if (room_tx) begin
						tx_push = 1'b1;
						idx_d   = 8'(idx_q + 1'b1);
					end
				end else begin
					s0_d[ST0_WACK] = !s0_q[ST0_WACK];
					st_d           = GSC_IDLE;
				end
			end
			GSC_SEND: begin
				if (adv) begin
					if (more) begin
						tv_d = 1'b1;
						if (fsrc_q) begin
							tx_d   = tx_dout;
							tl_d   = (tx_count == CW'(1));
							tx_pop = 1'b1;
						end else begin
							tx_d  = ctl.data[idx_q*8 +: 8];
							tl_d  = (idx_q == 8'(nlim - 1'b1));
							idx_d = 8'(idx_q + 1'b1);
						end
					end else begin
						tv_d = 1'b0;
						tl_d = 1'b0;
						if (fsrc_q) begin
							s0_d[ST0_WACK] = !s0_q[ST0_WACK];
						end
						st_d = GSC_IDLE;
					end
				end
			end
			default: begin
				st_d = GSC_IDLE;
			end
		endcase

		pend_d = pend_d | ctl.ev;
		s0_d[ST0_DEX] = (CW'(rx_count + CW'(rx_push) - CW'(rx_pop)) != '0);
		// The overflow flag tracks the pool, so it drops once space frees.
		s0_d[ST0_BO] = !room || (ser_rx_valid && !transparent && !room);
		rts_d = !s0_d[ST0_BO];
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			st_q    <= GSC_IDLE;
			sh_q    <= '0;
			in_q    <= '0;
			cnt_q   <= '0;
			idx_q   <= '0;
			trunc_q <= 1'b0;
			s0_q    <= STATUS0_RST;
			s1_q    <= STATUS1_RST;
			rts_q   <= 1'b0;
			tv_q    <= 1'b0;
			tx_q    <= '0;
			tl_q    <= 1'b0;
			tb_q    <= 1'b0;
			ta_q    <= '0;
			fsrc_q  <= 1'b0;
			cv_q    <= 1'b0;
			cd_q    <= '0;
			cl_q    <= '0;
			pend_q  <= '0;
		end else begin
			st_q    <= st_d;
			sh_q    <= sh_d;
			in_q    <= in_d;
			cnt_q   <= cnt_d;
			idx_q   <= idx_d;
			trunc_q <= trunc_d;
			s0_q    <= s0_d;
			s1_q    <= s1_d;
			rts_q   <= rts_d;
			tv_q    <= tv_d;
			tx_q    <= tx_d;
			tl_q    <= tl_d;
			tb_q    <= tb_d;
			ta_q    <= ta_d;
			fsrc_q  <= fsrc_d;
			cv_q    <= cv_d;
			cd_q    <= cd_d;
			cl_q    <= cl_d;
			pend_q  <= pend_d;
		end
	end

	// ********************************************************
	// Outputs
	// ********************************************************
	assign status0      = s0_q;
	assign status1      = s1_q;
	assign in_data      = in_q;
	assign rts          = rts_q;
	assign ser_tx_valid = tv_q;
	assign ser_tx_data  = tx_q;
	assign ser_tx_last  = tl_q;
	assign tx_bcast     = tb_q;
	assign tx_addr      = ta_q;
	assign cmd_valid    = cv_q;
	assign cmd_data     = cd_q;
	assign cmd_len      = cl_q;
endmodule // gsc_gateway
`default_nettype wire

// ---- testbench/gsc_gateway_asserts.sv ----
/* Port checker of the gateway status and control logic.
   Bound to every gsc_gateway; FB follows the instance. */
`timescale 1ns/1ps
`default_nettype none
module gsc_chk #(
	parameter int FB = 8
) (
	input wire logic            clk,          // Clock.
	input wire logic            rst_n,        // Reset, active low.
	input wire logic            transparent,  // Mode.
	input wire logic            coupler,      // Coupler fitted.
	input wire logic            img_wr,       // Image strobe.
	input wire logic [7:0]      ctrl0,        // Control byte 0.
	input wire logic [7:0]      status0,      // Status byte 0.
	input wire logic [7:0]      status1,      // Length count.
	input wire logic [FB*8-1:0] in_data,      // Data to master.
	input wire logic            ser_rx_valid, // Rx byte.
	input wire logic            ser_rx_last,  // Rx end.
	input wire logic            rts,          // RTS.
	input wire logic            tx_bcast,     // Broadcast.
	input wire logic [4:0]      tx_addr,      // Address.
	input wire logic            cmd_valid     // Command pulse.
);
	import gsc_pkg::*;
	// ********************************************************
	// Properties
	// ********************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	sequence s_msg_end;
		ser_rx_valid && ser_rx_last && transparent;
	endsequence
	sequence s_cmd_req;
		$past(img_wr, 3) && $past(ctrl0[CT0_CMD], 3);
	endsequence
	// RTS drops in the same cycle as the flag; the check still skips the first flag cycle.
	property p_rts_off;
		status0[ST0_BO] && $past(status0[ST0_BO]) |-> !rts;
	endproperty
	property p_dl_stick;
		status0[ST0_DL] |=> status0[ST0_DL];
	endproperty
	property p_len_cap;
		status1 <= FB;
	endproperty
	property p_zero_fill;
		status1 < FB |-> (in_data >> (8 * status1)) == '0;
	endproperty
	property p_rst_zero;
		$rose(rst_n) |-> status0 == STATUS0_RST && status1 == STATUS1_RST;
	endproperty
	property p_blr_coll;
		$changed(status0[ST0_BLR]) |-> !transparent;
	endproperty
	property p_nd_tog;
		s_msg_end |=> $changed(status0[ST0_ND]);
	endproperty
	property p_no_coupler;
		!coupler |-> !tx_bcast && tx_addr == 5'h00;
	endproperty
	property p_cmd;
		cmd_valid |-> s_cmd_req;
	endproperty
	a_rts_off: assert property (p_rts_off)
		else $error("rts asserted during overflow");
	a_dl_stick: assert property (p_dl_stick)
		else $error("data loss cleared without reset");
	a_len_cap: assert property (p_len_cap)
		else $error("length above frame size");
	a_zero_fill: assert property (p_zero_fill)
		else $error("data above length not zero");
	a_rst_zero: assert property (p_rst_zero)
		else $error("status not zero after reset");
	a_blr_coll: assert property (p_blr_coll)
		else $error("block ready toggled in transparent mode");
	a_nd_tog: assert property (p_nd_tog)
		else $error("new data not toggled after message");
	a_no_coupler: assert property (p_no_coupler)
		else $error("address used without coupler");
	a_cmd: assert property (p_cmd)
		else $error("command pulse without command image");
endmodule // gsc_chk
bind gsc_gateway gsc_chk #(.FB(FB)) i_chk (.clk(clk), .rst_n(rst_n),
	.transparent(transparent), .coupler(coupler), .img_wr(img_wr),
	.ctrl0(ctrl0), .status0(status0), .status1(status1), .in_data(in_data),
	.ser_rx_valid(ser_rx_valid), .ser_rx_last(ser_rx_last), .rts(rts),
	.tx_bcast(tx_bcast), .tx_addr(tx_addr), .cmd_valid(cmd_valid));
`default_nettype wire

// ---- testbench/gsc_master_model.sv ----
/* Fieldbus master model: writes the control image and reads blocks.
   Assumes the bench changes its requests just after a rising edge. */
`timescale 1ns/1ps
`default_nettype none
module gsc_master_model #(
	parameter int FB = 8
) (
	input  wire logic            clk,     // Clock.
	input  wire logic            go,      // Write image next cycle.
	input  wire logic [7:0]      c0_in,   // Wanted control byte 0.
	input  wire logic [7:0]      c1_in,   // Wanted control byte 1.
	input  wire logic [FB*8-1:0] d_in,    // Wanted data bytes.
	input  wire logic [7:0]      n_in,    // Wanted byte count.
	input  wire logic [7:0]      status0, // Status byte 0.
	input  wire logic [7:0]      status1, // Length count.
	input  wire logic [FB*8-1:0] in_data, // Data from gateway.
	output logic                 img_wr,  // Image strobe.
	output logic      [7:0]      ctrl0,   // Control byte 0.
	output logic      [7:0]      ctrl1,   // Control byte 1.
	output logic      [FB*8-1:0] m_data,  // Data bytes.
	output logic      [7:0]      m_len,   // Byte count.
	output logic      [7:0]      got_len, // Length of last block.
	output logic      [FB*8-1:0] got_data // Last block.
);
	import gsc_pkg::*;
	logic g;
	logic blr_q;
	initial begin
		img_wr = 1'b0;
		ctrl0 = CTRL_RST;
		ctrl1 = CTRL_RST;
		m_data = '0;
		m_len = 8'h00;
		got_len = 8'h00;
		got_data = '0;
		blr_q = 1'b0;
	end
	// Status is read before this edge updates it, so a whole set is taken.
	always @(posedge clk) begin
		g = go;
		if (status0[ST0_BLR] !== blr_q) begin
			got_len = status1;
			got_data = in_data;
		end
		blr_q = status0[ST0_BLR];
		#1;
		img_wr = g;
		if (g) begin
			ctrl0 = c0_in;
			ctrl1 = c1_in;
			m_data = d_in;
			m_len = n_in;
		end
	end
endmodule // gsc_master_model
`default_nettype wire

// ---- testbench/testbench.sv ----
/* Self-checking bench of gsc_gateway with a small shared pool.
   Assumes the master model and bound checker are compiled with it. */
`timescale 1ns/1ps
`default_nettype none
module testbench;
	import gsc_pkg::*;
	`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
		mismatches++; $display("BAD %s exp %h got %h", n, e, s); end end
	typedef struct {int n; logic [7:0] len; logic dl;} gsc_row_s;
	localparam logic [63:0] TD = 64'h0000_0000_0000_b2b1;
	gsc_row_s rows [4] = '{'{1, 8'h01, 1'b0}, '{3, 8'h03, 1'b0},
		'{8, 8'h08, 1'b0}, '{10, 8'h08, 1'b1}};
	int mismatches = 0;
	int checked = 0;
	int nb;
	logic clk = 1'b0, rst_n = 1'b0, transparent = 1'b1, coupler = 1'b0;
	logic ser_rx_valid = 1'b0, ser_rx_last = 1'b0, ser_tx_ready = 1'b0;
	logic go = 1'b0, old, lst, tb_b;
	logic [7:0] ser_rx_data = 8'h00, c0v = 8'h00, c1v = 8'h00, m_n;
	logic [7:0] ctrl0, ctrl1, m_len, status0, status1, cmd_len, got_len;
	logic [7:0] ser_tx_data;
	logic [63:0] m_data, in_data, cmd_data, got_data;
	logic [15:0] tx_w;
	logic [4:0] tx_addr, ta;
	logic img_wr, rts, ser_tx_valid, ser_tx_last, tx_bcast, cmd_valid;
	always #4 clk = ~clk;
	gsc_gateway #(.FB(8), .BUF(16)) i_dut (.clk(clk), .rst_n(rst_n),
		.transparent(transparent), .coupler(coupler), .img_wr(img_wr),
		.ctrl0(ctrl0), .ctrl1(ctrl1), .m_data(m_data), .m_len(m_len),
		.status0(status0), .status1(status1), .in_data(in_data),
		.ser_rx_valid(ser_rx_valid), .ser_rx_data(ser_rx_data),
		.ser_rx_last(ser_rx_last), .rts(rts), .ser_tx_valid(ser_tx_valid),
		.ser_tx_data(ser_tx_data), .ser_tx_last(ser_tx_last),
		.ser_tx_ready(ser_tx_ready), .tx_bcast(tx_bcast), .tx_addr(tx_addr),
		.cmd_valid(cmd_valid), .cmd_data(cmd_data), .cmd_len(cmd_len));
	gsc_master_model #(.FB(8)) i_mst (.clk(clk), .go(go), .c0_in(c0v),
		.c1_in(c1v), .d_in(TD), .n_in(m_n), .status0(status0),
		.status1(status1), .in_data(in_data), .img_wr(img_wr), .ctrl0(ctrl0),
		.ctrl1(ctrl1), .m_data(m_data), .m_len(m_len), .got_len(got_len),
		.got_data(got_data));
	// ********************************************************
	// Tasks
	// ********************************************************
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic rx(input int n);
		for (int i = 0; i < n; i++) begin
			ser_rx_valid = 1'b1;
			ser_rx_data = 8'h10 + 8'(i);
			ser_rx_last = (i == n - 1);
			tick(1);
		end
		ser_rx_valid = 1'b0;
		ser_rx_last = 1'b0;
	endtask
	task automatic img(input logic [7:0] n);
		m_n = n;
		go = 1'b1;
		tick(1);
		go = 1'b0;
	endtask
	task automatic waitfor(input int b, input logic o);
		for (int i = 0; i < 200 && status0[b] === o; i++) tick(1);
	endtask
	task automatic rack;
		old = status0[ST0_BLR];
		c1v ^= 8'h01 << CT1_RACK;
		img(8'h00);
		waitfor(ST0_BLR, old);
		tick(1);
	endtask
	function automatic logic [63:0] exp_data(input int k);
		logic [63:0] v;
		v = '0;
		for (int i = 0; i < k; i++) v[8*i+:8] = 8'h10 + 8'(i);
		return v;
	endfunction
	task automatic end_sim;
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		#100000;
		mismatches++;
		end_sim();
	end
	// ********************************************************
	// Tests
	// ********************************************************
	initial begin
		tick(5);
		rst_n = 1'b1;
		tick(1);
		foreach (rows[j]) begin
			old = status0[ST0_ND];
			rx(rows[j].n);
			tick(1);
			`CHK("len", rows[j].len, status1)
			`CHK("data", exp_data(rows[j].len), in_data)
			`CHK("nd", ~old, status0[ST0_ND])
			`CHK("dl", rows[j].dl, status0[ST0_DL])
		end
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
		transparent = 1'b0;
		tick(2);
		`CHK("st0_rst", STATUS0_RST, status0)
		rx(3);
		tick(2);
		`CHK("dex", 1'b1, status0[ST0_DEX])
		rack();
		`CHK("blk_len", 8'h03, got_len)
		`CHK("blk_data", exp_data(3), got_data)
		`CHK("dex_off", 1'b0, status0[ST0_DEX])
		// The address is ignored without a coupler, used with one.
		for (int k = 0; k < 2; k++) begin
			coupler = k[0];
			c0v = (8'h15 << CT0_ADDR) | (8'h01 << CT0_BCAST);
			old = status0[ST0_WACK];
			c1v ^= 8'h01 << CT1_CTB;
			img(8'h02);
			waitfor(ST0_WACK, old);
			`CHK("wack_ctb", ~old, status0[ST0_WACK])
			c1v ^= 8'h01 << CT1_SFB;
			img(8'h02);
			nb = 0;
			for (int i = 0; i < 60; i++) begin
				@(posedge clk);
				if (ser_tx_valid === 1'b1 && ser_tx_ready === 1'b1) begin
					tx_w = {ser_tx_data, tx_w[15:8]};
					lst = ser_tx_last;
					ta = tx_addr;
					tb_b = tx_bcast;
					nb++;
				end
				#1 ser_tx_ready = ~ser_tx_ready;
			end
			`CHK("tx_n", 2, nb)
			`CHK("tx_data", TD[15:0], tx_w)
			`CHK("tx_last", 1'b1, lst)
			`CHK("tx_addr", (k ? 5'h15 : 5'h00), ta)
			`CHK("tx_bcast", k[0], tb_b)
			`CHK("wack_sfb", old, status0[ST0_WACK])
		end
		rx(17);
		tick(2);
		`CHK("bo", 1'b1, status0[ST0_BO])
		`CHK("rts_off", 1'b0, rts)
		`CHK("dl_ovf", 1'b1, status0[ST0_DL])
		rack();
		tick(2);
		`CHK("ovf_len", 8'h08, got_len)
		`CHK("bo_clr", 1'b0, status0[ST0_BO])
		`CHK("rts_on", 1'b1, rts)
		// Eight copied bytes fill the pool beside eight received ones.
		old = status0[ST0_WACK];
		c1v ^= 8'h01 << CT1_CTB;
		img(8'h08);
		waitfor(ST0_WACK, old);
		rx(1);
		tick(2);
		`CHK("bo_shared", 1'b1, status0[ST0_BO])
		c0v = c0v ^ (8'h01 << CT0_ND);
		c0v[CT0_CMD] = 1'b1;
		img(8'h02);
		for (int i = 0; i < 10 && cmd_valid !== 1'b1; i++) tick(1);
		`CHK("cmd_v", 1'b1, cmd_valid)
		`CHK("cmd_d", TD[15:0], cmd_data[15:0])
		`CHK("cmd_n", 8'h02, cmd_len)
		`CHK("cmd_tx", 1'b0, ser_tx_valid)
		end_sim();
	end
endmodule // testbench
`default_nettype wire
